// ---- timer_half.sv ----
// One 16-bit timer half: one-shot, periodic, edge count, edge time, PWM.
// Assumes an AXI4-Lite master on aclk; pin and halt inputs are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module timer_half #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Write address and data
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// Write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// Read address and data
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Pins and system signals
	input  wire logic              capture_compare_pin,
	input  wire logic              debug_halt,
	output logic                   irq,
	output logic                   adc_trigger,
	output logic                   pwm_out
);
	timer_pkg::state_s s_q;   // Registered state
	timer_pkg::state_s s_d;   // Next state
	timer_pkg::op_e    op;    // Decoded mode
	logic              wr;    // Write taken this cycle
	logic              rd;    // Read taken this cycle
	logic              rise;  // Synced rising edge
	logic              fall;  // Synced falling edge
	logic              hit;   // Qualifying edge
	logic              run;   // Enabled and not stalled
	logic [15:0]       dec;   // Count minus one
	logic [31:0]       wm;    // Write data merged with old

	// Mode decode; alternate select wins only with the periodic mode field and cmr clear
	function automatic timer_pkg::op_e op_of(input timer_pkg::regs_s r);
		// PWM needs all three mode fields, so it is tested first
		if (r.ams && !r.cmr && r.mr == timer_pkg::MR_PERIOD)
			return timer_pkg::OP_PWM;
		case (r.mr)
			timer_pkg::MR_ONESHOT: return timer_pkg::OP_ONE;
			timer_pkg::MR_PERIOD:  return timer_pkg::OP_PER;
			timer_pkg::MR_CAPTURE:
				return r.cmr ? timer_pkg::OP_ETIME : timer_pkg::OP_ECNT;
			default:               return timer_pkg::OP_OFF;
		endcase
	endfunction

	// Address known to the register map
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		case (8'(a))
			timer_pkg::OFF_CFG, timer_pkg::OFF_MODE, timer_pkg::OFF_CTL,
			timer_pkg::OFF_IMR, timer_pkg::OFF_RIS, timer_pkg::OFF_MIS,
			timer_pkg::OFF_ICR, timer_pkg::OFF_ILR, timer_pkg::OFF_MATCH,
			timer_pkg::OFF_PRE, timer_pkg::OFF_VAL: return 1'b1;
			default:                                  return 1'b0;
		endcase
	endfunction

	// Read value of one register
	function automatic logic [31:0] rd_val(input timer_pkg::state_s s,
		input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (8'(a))
			timer_pkg::OFF_CFG:   v[2:0] = s.r.cfg;
			timer_pkg::OFF_MODE:  v[3:0] = {s.r.ams, s.r.cmr, s.r.mr};
			timer_pkg::OFF_CTL:   v[6:0] = {s.r.pwml, s.r.ote, 1'b0, s.r.evt,
				s.r.stall, s.r.en};
			timer_pkg::OFF_IMR:   v[2:0] = s.r.imr;
			timer_pkg::OFF_RIS:   v[2:0] = s.raw;
			timer_pkg::OFF_MIS:   v[2:0] = s.raw & s.r.imr;
			timer_pkg::OFF_ILR:   v[15:0] = s.r.ilr;
			timer_pkg::OFF_MATCH: v[15:0] = s.r.match;
			timer_pkg::OFF_PRE:   v[7:0] = s.r.pre;
			// Edge time shows the held capture, otherwise the live count
			timer_pkg::OFF_VAL:   v[15:0] = (op_of(s.r) == timer_pkg::OP_ETIME)
				? s.cap : s.cnt;
			default:              v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Byte-lane merge of write data into the old value
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] st);
		logic [31:0] v;
		v = o;
		for (int i = 0; i < 4; i++)
			if (st[i])
				v[i*8 +: 8] = d[i*8 +: 8];
		return v;
	endfunction

	// Handshake and edge helpers
	assign wr   = s_q.awrdy & awvalid & wvalid;
	assign rd   = s_q.arrdy & arvalid;
	assign rise = s_q.pin2 & ~s_q.pin3;
	assign fall = ~s_q.pin2 & s_q.pin3;
	assign op   = op_of(s_q.r);
	assign run  = s_q.r.en & ~(s_q.r.stall & s_q.hlt2);
	assign dec  = s_q.cnt - 16'h0001;
	assign wm   = merge(rd_val(s_q, awaddr), wdata, wstrb);
	// Edge time never counts both edges; both falls back to rising
	assign hit  = (s_q.r.evt == timer_pkg::EVT_RISE) ? rise
		: (s_q.r.evt == timer_pkg::EVT_FALL) ? fall
		: (s_q.r.evt == timer_pkg::EVT_BOTH)
			? (op == timer_pkg::OP_ETIME ? rise : rise | fall)
		: 1'b0;

	// Next-state logic: counting first, then bus writes override
	always_comb
	begin
		logic [2:0] set;
		logic [2:0] clr;
		set = 3'h0;
		clr = 3'h0;
		s_d = s_q;
		// Two-stage synchronisers, third stage for edges
		s_d.pin1 = capture_compare_pin;
		s_d.pin2 = s_q.pin1;
		s_d.pin3 = s_q.pin2;
		s_d.hlt1 = debug_halt;
		s_d.hlt2 = s_q.hlt1;
		s_d.trig = 1'b0;
		case (op)
			// Prescaled down-count
			timer_pkg::OP_ONE, timer_pkg::OP_PER:
				if (run)
				begin
					// Reload waits out the prescale too: a period is (n+1)(p+1)
					if (s_q.pc != 8'h00)
						s_d.pc = s_q.pc - 8'h01;
					else if (s_q.cnt == 16'h0000)
					begin
						s_d.cnt = s_q.r.ilr;
						s_d.pc = s_q.r.pre;
						set[timer_pkg::ST_TO] = 1'b1;
						s_d.trig = s_q.r.ote;
						if (op == timer_pkg::OP_ONE)
							s_d.r.en = 1'b0;
					end
					else
					begin
						s_d.cnt = dec;
						s_d.pc = s_q.r.pre;
					end
				end
			// Count edges down to the match value
			timer_pkg::OP_ECNT:
				if (run && hit)
				begin
					if (dec == s_q.r.match)
					begin
						s_d.cnt = s_q.r.ilr;
						s_d.r.en = 1'b0;
						set[timer_pkg::ST_CM] = 1'b1;
					end
					else
						s_d.cnt = dec;
				end
			// Free run with capture
			timer_pkg::OP_ETIME:
				if (run)
				begin
					s_d.cnt = (s_q.cnt == 16'h0000) ? s_q.r.ilr : dec;
					if (hit)
					begin
						s_d.cap = s_q.cnt;
						set[timer_pkg::ST_CE] = 1'b1;
					end
				end
			// PWM: no status, level set at start, cleared at match
			timer_pkg::OP_PWM:
				if (run)
				begin
					s_d.cnt = (s_q.cnt == 16'h0000) ? s_q.r.ilr : dec;
					if (s_q.cnt == s_q.r.ilr)
						s_d.lvl = 1'b1;
					else if (s_q.cnt == s_q.r.match)
						s_d.lvl = 1'b0;
				end
			// Unused mode codes hold everything
			default:
				s_d.cnt = s_q.cnt;
		endcase
		// Register writes; a write wins over a hardware enable clear
		if (wr)
		begin
			case (8'(awaddr))
				timer_pkg::OFF_CFG:   s_d.r.cfg = wm[2:0];
				timer_pkg::OFF_MODE:
				begin
					s_d.r.mr = wm[timer_pkg::MODE_MR +: 2];
					s_d.r.cmr = wm[timer_pkg::MODE_CMR];
					s_d.r.ams = wm[timer_pkg::MODE_AMS];
				end
				timer_pkg::OFF_CTL:
				begin
					s_d.r.en = wm[timer_pkg::CTL_EN];
					s_d.r.stall = wm[timer_pkg::CTL_STALL];
					s_d.r.evt = wm[timer_pkg::CTL_EVT +: 2];
					s_d.r.ote = wm[timer_pkg::CTL_OTE];
					s_d.r.pwml = wm[timer_pkg::CTL_PWML];
				end
				timer_pkg::OFF_IMR:   s_d.r.imr = wm[2:0];
				timer_pkg::OFF_ICR:   clr = wdata[2:0] & {3{wstrb[0]}};
				timer_pkg::OFF_ILR:
				begin
					s_d.r.ilr = wm[15:0];
					s_d.cnt = wm[15:0];
					s_d.pc = s_q.r.pre;
				end
				timer_pkg::OFF_MATCH: s_d.r.match = wm[15:0];
				timer_pkg::OFF_PRE:
				begin
					s_d.r.pre = wm[7:0];
					s_d.pc = wm[7:0];
				end
				// Read-only or unmapped: ignored
				default:              clr = 3'h0;
			endcase
		end
		// Set beats clear in the same cycle
		s_d.raw = (s_q.raw & ~clr) | set;
		s_d.irq = |(s_d.raw & s_d.r.imr);
		s_d.pwm = s_d.lvl ^ s_d.r.pwml;
		// Write channel: ready pulses once both address and data wait
		s_d.awrdy = ~s_q.awrdy & ~s_q.bvalid & awvalid & wvalid;
		if (wr)
		begin
			s_d.bvalid = 1'b1;
			s_d.bresp = mapped(awaddr) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLV;
		end
		else if (s_q.bvalid && bready)
			s_d.bvalid = 1'b0;
		// Read channel
		s_d.arrdy = ~s_q.arrdy & ~s_q.rvalid & arvalid;
		if (rd)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_val(s_q, araddr);
			s_d.rresp = mapped(araddr) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLV;
		end
		else if (s_q.rvalid && rready)
			s_d.rvalid = 1'b0;
		// Synchronous reset to documented defaults
		if (!aresetn)
		begin
			s_d = '0;
			s_d.r.cfg = timer_pkg::RST_CFG;
			s_d.r.ilr = timer_pkg::RST_ILR;
			s_d.r.pre = timer_pkg::RST_PRE;
			s_d.cnt = timer_pkg::RST_CNT;
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		s_q <= s_d;
	end

	// Outputs straight from flip-flops
	assign awready     = s_q.awrdy;
	assign wready      = s_q.awrdy;
	assign bvalid      = s_q.bvalid;
	assign bresp       = s_q.bresp;
	assign arready     = s_q.arrdy;
	assign rvalid      = s_q.rvalid;
	assign rdata       = s_q.rdata;
	assign rresp       = s_q.rresp;
	assign irq         = s_q.irq;
	assign adc_trigger = s_q.trig;
	assign pwm_out     = s_q.pwm;

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic tmo;  // Time-out condition
	assign tmo = (op == timer_pkg::OP_ONE || op == timer_pkg::OP_PER)
		&& run && s_q.cnt == 16'h0000 && s_q.pc == 8'h00;

	chk_timeout_reload: assert property (tmo && !wr |=> s_q.cnt == $past(s_q.r.ilr))
		else $error("no reload at zero");
	chk_oneshot_stop: assert property (tmo && !wr && op == timer_pkg::OP_ONE
		|=> !s_q.r.en)
		else $error("one-shot kept running");
	chk_timeout_flag: assert property (tmo |=> s_q.raw[timer_pkg::ST_TO] ##1
		s_q.raw[timer_pkg::ST_TO] || $past(wr))
		else $error("time-out flag lost");
	chk_irq_follows: assert property (s_q.raw[timer_pkg::ST_TO] && s_q.r.imr[timer_pkg::ST_TO]
		|-> irq)
		else $error("irq missing");
	chk_adc_trigger: assert property (adc_trigger |-> $past(tmo) && $past(s_q.r.ote))
		else $error("stray adc trigger");
	chk_ilr_load: assert property (wr && 8'(awaddr) == timer_pkg::OFF_ILR && wstrb == 4'hf
		|=> s_q.cnt == $past(wdata[15:0]))
		else $error("load not taken");
	chk_stall_hold: assert property (s_q.r.en && s_q.r.stall && s_q.hlt2 && !wr
		|=> $stable(s_q.cnt))
		else $error("count moved in halt");
	chk_prescale_wait: assert property (op == timer_pkg::OP_PER && run && s_q.pc != 8'h00
		&& s_q.cnt != 16'h0000 && !wr |=> $stable(s_q.cnt))
		else $error("early decrement");
	chk_edge_match: assert property (op == timer_pkg::OP_ECNT && run && hit
		&& dec == s_q.r.match && !wr |=> !s_q.r.en && s_q.raw[timer_pkg::ST_CM])
		else $error("edge count no stop");
	chk_capture_copy: assert property (op == timer_pkg::OP_ETIME && run && hit
		|=> s_q.cap == $past(s_q.cnt) && s_q.raw[timer_pkg::ST_CE])
		else $error("capture wrong");
	chk_pwm_quiet: assert property (op == timer_pkg::OP_PWM && !wr
		|=> s_q.raw == $past(s_q.raw))
		else $error("status in pwm");
	chk_pwm_start: assert property (op == timer_pkg::OP_PWM && run && !wr
		&& s_q.cnt == s_q.r.ilr |=> pwm_out == !s_q.r.pwml)
		else $error("pwm not asserted");

	cov_timeout: cover property (tmo ##1 irq);
	cov_edge_stop: cover property (op == timer_pkg::OP_ECNT && $fell(s_q.r.en));
	cov_capture: cover property ($rose(s_q.raw[timer_pkg::ST_CE]));
	cov_pwm_cycle: cover property ($rose(s_q.lvl) ##[1:300] $fell(s_q.lvl));
endmodule
`default_nettype wire

// ---- timer_pkg.sv ----
// Constants, types and state layout of the 16-bit timer half.
// Assumes an AXI4-Lite master with 32-bit data and one clock.
// Behaviour
// - Enable starts down-count; zero reloads once the prescale runs out
// - One-shot clears enable at zero; periodic continues
// - Time-out sets raw flag until cleared
// - Unmasked time-out sets masked flag, interrupt
// - Time-out triggers ADC only when enabled
// - Interval load write reloads counter next cycle
// - Stall enable freezes count during debug halt
// - Prescale N gives N+1 clocks per count
// - Prescaler bypassed in capture and PWM modes
// - Edge count uses rising, falling or both
// - Each edge decrements; match sets match flags
// - After match reload, disable, ignore further edges
// - Edge time runs free from interval load
// - Selected edge captures count, sets capture flags; both captures on rising only
// - Edge time keeps running, reloads at zero
// - Captured value holds until next selected edge
// - PWM reloads at zero, raises no status
// - PWM sets at start value, clears at match
// - Output invert bit inverts PWM signal
// - Mode field one-shot is 1, periodic 2
// - Mode field 3 is capture, bit selects
// - Counter and load reset 0xFFFF, prescale 0
package timer_pkg;
	// Byte offsets
	localparam logic [7:0]  OFF_CFG    = 8'h00;
	localparam logic [7:0]  OFF_MODE   = 8'h04;
	localparam logic [7:0]  OFF_CTL    = 8'h0c;
	localparam logic [7:0]  OFF_IMR    = 8'h18;
	localparam logic [7:0]  OFF_RIS    = 8'h1c;
	localparam logic [7:0]  OFF_MIS    = 8'h20;
	localparam logic [7:0]  OFF_ICR    = 8'h24;
	localparam logic [7:0]  OFF_ILR    = 8'h28;
	localparam logic [7:0]  OFF_MATCH  = 8'h30;
	localparam logic [7:0]  OFF_PRE    = 8'h38;
	localparam logic [7:0]  OFF_VAL    = 8'h48;
	// Control register bits
	localparam int          CTL_EN     = 0;
	localparam int          CTL_STALL  = 1;
	localparam int          CTL_EVT    = 2;
	localparam int          CTL_OTE    = 5;
	localparam int          CTL_PWML   = 6;
	// Mode register bits
	localparam int          MODE_MR    = 0;
	localparam int          MODE_CMR   = 2;
	localparam int          MODE_AMS   = 3;
	// Status bits
	localparam int          ST_TO      = 0;
	localparam int          ST_CM      = 1;
	localparam int          ST_CE      = 2;
	// Field encodings
	localparam logic [1:0]  MR_ONESHOT = 2'h1;
	localparam logic [1:0]  MR_PERIOD  = 2'h2;
	localparam logic [1:0]  MR_CAPTURE = 2'h3;
	localparam logic [1:0]  EVT_RISE   = 2'h0;
	localparam logic [1:0]  EVT_FALL   = 2'h1;
	localparam logic [1:0]  EVT_BOTH   = 2'h3;
	localparam logic [2:0]  CFG_16BIT  = 3'h4;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;
	// Reset values
	localparam logic [15:0] RST_CNT    = 16'hffff;
	localparam logic [15:0] RST_ILR    = 16'hffff;
	localparam logic [7:0]  RST_PRE    = 8'h00;
	localparam logic [2:0]  RST_CFG    = 3'h0;

	// Decoded operating mode
	typedef enum logic [5:0] {
		OP_OFF   = 6'h01,
		OP_ONE   = 6'h02,
		OP_PER   = 6'h04,
		OP_ECNT  = 6'h08,
		OP_ETIME = 6'h10,
		OP_PWM   = 6'h20
	} op_e;

	// Software-visible registers
	typedef struct packed {
		logic [2:0]  cfg;
		logic [1:0]  mr;
		logic        cmr;
		logic        ams;
		logic        en;
		logic        stall;
		logic [1:0]  evt;
		logic        ote;
		logic        pwml;
		logic [2:0]  imr;
		logic [15:0] ilr;
		logic [15:0] match;
		logic [7:0]  pre;
	} regs_s;

	// Whole state of the block
	typedef struct packed {
		regs_s       r;
		logic [2:0]  raw;
		logic [15:0] cnt;
		logic [7:0]  pc;
		logic [15:0] cap;
		logic        pin1;
		logic        pin2;
		logic        pin3;
		logic        hlt1;
		logic        hlt2;
		logic        lvl;
		logic        pwm;
		logic        trig;
		logic        irq;
		logic        awrdy;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arrdy;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} state_s;
endpackage

// ---- pin_model.sv ----
// Far-side model: drives the capture pin and the debugger halt line.
// Assumes its tasks are called from a process that runs on aclk edges.
`timescale 1ns/10ps
`default_nettype none
module pin_model (
	// Clock
	input  wire logic aclk,
	// Lines driven toward the timer
	output var logic  capture_compare_pin,
	output var logic  debug_halt
);
	// Both lines idle low from time zero
	initial
	begin
		capture_compare_pin = 1'b0;
		debug_halt = 1'b0;
	end

	// Toggle the pin n times; a shorter hold than two clocks is never made
	task automatic toggle(input int n, input int hold);
		repeat (n)
		begin
			@(posedge aclk);
			capture_compare_pin <= ~capture_compare_pin;
			repeat ((hold < 2 ? 2 : hold) - 1) @(posedge aclk);
		end
	endtask

	// Hold the processor halted for h clocks
	task automatic halt(input int h);
		@(posedge aclk);
		debug_halt <= 1'b1;
		repeat (h) @(posedge aclk);
		debug_halt <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- timer_half_bench.sv ----
// Self-checking bench for the 16-bit timer half.
// Assumes the pin model above and the package's register map.
`timescale 1ns/10ps
`default_nettype none
module timer_half_bench;
	// Bus and system signals
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, v, v1;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        irq, adc_trigger, pwm_out;
	wire         pin, halt;
	// Counters and scratch
	int          errors, n_checks, cyc, last_t, per, ntrig, s, n, p, h, hi, m;
	logic [1:0]  evts [3] = '{timer_pkg::EVT_RISE, timer_pkg::EVT_FALL, timer_pkg::EVT_BOTH};

	timer_half #(.ADDR_W(8)) timer_half_inst (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.capture_compare_pin(pin), .debug_halt(halt), .irq(irq),
		.adc_trigger(adc_trigger), .pwm_out(pwm_out)
	);
	pin_model pin_model_inst (.aclk(aclk), .capture_compare_pin(pin), .debug_halt(halt));

	// Free-running clock, 40 ns period
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Interval between trigger pulses, in clocks
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (adc_trigger === 1'b1)
		begin
			per <= cyc - last_t;
			last_t <= cyc;
			ntrig <= ntrig + 1;
		end
	end

	// Expected clocks per period, stall added
	function automatic int per_exp(input int n, input int p, input int h);
		return (n + 1) * (p + 1) + h;
	endfunction

	// Edges of kind e in t toggles from a low pin
	function automatic int edges(input logic [1:0] e, input int t);
		return e == timer_pkg::EVT_BOTH ? t : (e == timer_pkg::EVT_RISE ? (t + 1) / 2 : t / 2);
	endfunction

	// High clocks per PWM period
	function automatic int pwm_hi(input int ilr, input int m, input int inv);
		return inv ? m + 1 : ilr - m;
	endfunction

	// Word comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus write; address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad;
		logic dd;
		ad = 1'b0;
		dd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge aclk);
			if (awready === 1'b1 && !ad)
			begin
				awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (wready === 1'b1 && !dd)
			begin
				wvalid <= 1'b0;
				dd = 1'b1;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		r = bresp;
	endtask

	// Bus read; data and response taken at the rvalid edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	// Wait for k more trigger pulses, bounded
	task automatic wait_trig(input int k);
		int t;
		t = ntrig + k;
		repeat (20000) if (ntrig < t) @(posedge aclk);
		if (ntrig < t)
		begin
			errors++;
			$display("mismatch at %0t: trigger wait timed out", $time);
		end
	endtask

	// Verdict; the only exit
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog; the whole run needs well under this
	initial
	begin
		#(40 * 90000);
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		complete_run;
	end

	// Main sequence
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{cyc, last_t, per, ntrig, errors, n_checks} = '0;
		wstrb = 4'hf;
		aresetn = 1'b0;
		void'($urandom(7064));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(timer_pkg::OFF_ILR, v); chk(v, 32'h0000ffff);
		rd(timer_pkg::OFF_PRE, v); chk(v, 32'h00000000);
		wr(timer_pkg::OFF_VAL, 32'h00000000); chk(r, timer_pkg::RESP_OKAY);
		rd(timer_pkg::OFF_VAL, v); chk(v, 32'h0000ffff);
		rd(8'h44, v); chk(r, timer_pkg::RESP_SLV);
		wr(8'h44, 32'h00000000); chk(r, timer_pkg::RESP_SLV);
		wr(timer_pkg::OFF_CFG, timer_pkg::CFG_16BIT);
		$display("test reset done");
		// Periodic with prescale, then a debugger halt mid-period
		for (int i = 0; i < 3; i++)
		begin
			n = i == 1 ? 30 : $urandom_range(60, 30);
			p = i == 0 ? 0 : (i == 1 ? 255 : $urandom_range(15, 1));
			h = $urandom_range(20, 5);
			wr(timer_pkg::OFF_PRE, p);
			wr(timer_pkg::OFF_ILR, n);
			wr(timer_pkg::OFF_MODE, timer_pkg::MR_PERIOD);
			wr(timer_pkg::OFF_CTL, 32'h00000023);
			wait_trig(2); chk(per, per_exp(n, p, 0));
			pin_model_inst.halt(h);
			wait_trig(1); chk(per, per_exp(n, p, h));
			wr(timer_pkg::OFF_CTL, 32'h00000000);
		end
		$display("test periodic done");
		// One-shot with unmasked time-out
		wr(timer_pkg::OFF_PRE, 0);
		wr(timer_pkg::OFF_ICR, 32'h00000007);
		wr(timer_pkg::OFF_IMR, 32'h00000001);
		wr(timer_pkg::OFF_ILR, 20);
		wr(timer_pkg::OFF_MODE, timer_pkg::MR_ONESHOT);
		wr(timer_pkg::OFF_CTL, 32'h00000021);
		wait_trig(1);
		s = ntrig;
		rd(timer_pkg::OFF_CTL, v); chk(v[0], 1'b0);
		rd(timer_pkg::OFF_RIS, v); chk(v, 32'h00000001);
		rd(timer_pkg::OFF_MIS, v); chk(v, 32'h00000001);
		chk(irq, 1'b1);
		repeat (60) @(posedge aclk);
		chk(ntrig, s);
		wr(timer_pkg::OFF_ICR, 32'h00000001);
		rd(timer_pkg::OFF_RIS, v); chk(v, 32'h00000000);
		chk(irq, 1'b0);
		// Periodic without trigger enable; interval rewritten on the fly
		wr(timer_pkg::OFF_MODE, timer_pkg::MR_PERIOD);
		wr(timer_pkg::OFF_CTL, 32'h00000001);
		repeat (100) @(posedge aclk);
		chk(ntrig, s);
		rd(timer_pkg::OFF_RIS, v); chk(v[0], 1'b1);
		wr(timer_pkg::OFF_ILR, 32'h00008000);
		rd(timer_pkg::OFF_VAL, v); chk(v <= 32'h8000 && v > 32'h7ff0, 1'b1);
		wr(timer_pkg::OFF_CTL, 32'h00000000);
		$display("test one-shot done");
		// Edge count for every edge kind; prescale left set to prove it unused
		wr(timer_pkg::OFF_PRE, 5);
		foreach (evts[k])
		begin
			wr(timer_pkg::OFF_ICR, 32'h00000007);
			wr(timer_pkg::OFF_MODE, timer_pkg::MR_CAPTURE);
			wr(timer_pkg::OFF_ILR, 10);
			wr(timer_pkg::OFF_MATCH, 6);
			wr(timer_pkg::OFF_CTL, {26'h0, evts[k], 2'b01});
			pin_model_inst.toggle(3, $urandom_range(5, 2));
			repeat (4) @(posedge aclk);
			rd(timer_pkg::OFF_VAL, v); chk(v, 10 - edges(evts[k], 3));
			pin_model_inst.toggle(7, $urandom_range(5, 2));
			repeat (4) @(posedge aclk);
			rd(timer_pkg::OFF_RIS, v); chk(v, 32'h00000002);
			rd(timer_pkg::OFF_CTL, v); chk(v[0], 1'b0);
			rd(timer_pkg::OFF_VAL, v); chk(v, 32'h0000000a);
		end
		$display("test edge count done");
		// Edge time on rising edges
		wr(timer_pkg::OFF_ICR, 32'h00000007);
		wr(timer_pkg::OFF_IMR, 32'h00000004);
		wr(timer_pkg::OFF_ILR, 32'h0000ffff);
		wr(timer_pkg::OFF_MODE, 32'h00000007);
		wr(timer_pkg::OFF_CTL, 32'h00000001);
		pin_model_inst.toggle(1, 3);
		repeat (4) @(posedge aclk);
		rd(timer_pkg::OFF_VAL, v1); chk(v1 < 32'hffff && v1 > 32'hff00, 1'b1);
		rd(timer_pkg::OFF_RIS, v); chk(v, 32'h00000004);
		chk(irq, 1'b1);
		pin_model_inst.toggle(1, 3);
		repeat (4) @(posedge aclk);
		rd(timer_pkg::OFF_VAL, v); chk(v, v1);
		pin_model_inst.toggle(1, 3);
		repeat (4) @(posedge aclk);
		rd(timer_pkg::OFF_VAL, v); chk(v < v1, 1'b1);
		wr(timer_pkg::OFF_CTL, 32'h00000000);
		$display("test edge time done");
		// PWM, plain and inverted, random match
		for (int inv = 0; inv < 2; inv++)
		begin
			m = $urandom_range(8, 1);
			wr(timer_pkg::OFF_ICR, 32'h00000007);
			wr(timer_pkg::OFF_MODE, 32'h0000000a);
			wr(timer_pkg::OFF_ILR, 9);
			wr(timer_pkg::OFF_MATCH, m);
			wr(timer_pkg::OFF_CTL, {25'h0, inv[0], 6'h01});
			repeat (30) @(posedge aclk);
			hi = 0;
			repeat (20)
			begin
				@(posedge aclk);
				if (pwm_out === 1'b1)
					hi++;
			end
			chk(hi, 2 * pwm_hi(9, m, inv));
			rd(timer_pkg::OFF_RIS, v); chk(v, 32'h00000000);
			wr(timer_pkg::OFF_CTL, 32'h00000000);
		end
		$display("test pwm done");
		complete_run;
	end
endmodule
`default_nettype wire
